// file: logic/dpc_pkg.sv
/*
  Shared constants for the converter clock-control pair: code widths, divider
  limits, lock and flush timing, and the rate table bounds used by the source.
  Assumes one 20 MHz system clock that both ends share.
*/
// How it works
// - Oscillator multiple: interpolation times prescaler, doubled when stuffing
// - Source flags input rate outside table limits (PLL on; RATE_CEIL cap always)
// - Source flags oscillator out of range; divider advice ignores it
// - Source picks prescaler from input sample rate
// - Source aims oscillator at 450 to 550 MHz
// - Lock indicator appears on a chosen pin
// - Sleep only gates converter currents, resumes at once
// - Power-down stops everything except configuration port
// - Source waits for filter flush after power-down
// - Both ports captured together on data-clock rise
// - PLL off: clock on shared or serial pin
// - PLL on, both clear: lock on shared pin
// - PLL on, select set: lock on serial pin
// - PLL on, clock-out set: clock on selected pin
// - Lock also readable as a status bit
// - PLL on: reference rate; off: divide internally
package dpc_pkg;
  localparam int unsigned SYS_CLK_HZ      = 20_000_000;
  localparam int unsigned SYS_PERIOD_NS   = 1_000_000_000 / SYS_CLK_HZ;
  localparam int unsigned DATA_W          = 16;
  localparam int unsigned CODE_W          = 2;
  localparam int unsigned CNT_W           = 4;
  localparam int unsigned RATIO_W         = 8;
  localparam int unsigned RATE_W          = 8;
  localparam int unsigned PROD_W          = 16;
  // Stand-in acquisition time of the loop model
  localparam int unsigned LOCK_TIME_NS    = 10_000;
  localparam int unsigned LOCK_CYCLES     = (LOCK_TIME_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
  localparam int unsigned LOCK_W          = 12;
  localparam int unsigned FLUSH_CYCLES    = 64;
  localparam int unsigned FLUSH_W         = 8;
  // Shortest data-clock period that a pin can show as a real square wave
  localparam logic [CNT_W-1:0] MIN_PERIOD = 4'h2;
  localparam logic [CNT_W-1:0] PLL_ON_PERIOD = 4'h2;
  localparam logic [8:0] RATE_CEIL        = 9'h0a0;
  localparam logic [8:0] MIN_BASE_X1      = 9'h020;
  localparam logic [8:0] MIN_BASE_XN      = 9'h018;
  localparam logic [8:0] MAX_BASE_DIV1    = 9'h190;
  localparam logic [8:0] MAX_BASE         = 9'h1c0;
  localparam logic [PROD_W-1:0] VCO_LO_MHZ = 16'h01c2;
  localparam logic [PROD_W-1:0] VCO_HI_MHZ = 16'h0226;
  localparam logic [RATE_W-1:0] RATE_DIV1 = 8'h7d;
  localparam logic [RATE_W-1:0] RATE_DIV2 = 8'h4b;
  localparam logic [RATE_W-1:0] RATE_DIV4 = 8'h32;
endpackage

// file: logic/dpc_link_if.sv
/*
  Pins between the converter clock block and the sample source.
  Assumes both ends run on the same system clock; the bench resolves nothing.
*/
`timescale 1ns/10ps
interface dpc_link_if;
  logic                          shared_pin;
  logic                          sdo_pin;
  logic                          sdo_oe;
  logic [dpc_pkg::DATA_W-1:0]    port1;
  logic [dpc_pkg::DATA_W-1:0]    port2;

  modport dev (output shared_pin, output sdo_pin, output sdo_oe, input port1, input port2);
  modport src (input shared_pin, input sdo_pin, input sdo_oe, output port1, output port2);
endinterface

// file: logic/dpc_clock_ctrl.sv
/*
  Converter end: data-rate clock generation, loop-lock model, pin routing,
  sleep and power-down gating, two-port capture.
  Assumes configuration bits are held steady by a configuration port outside.
*/
`timescale 1ns/10ps
module dpc_clock_ctrl (
  input  wire logic                           clk_sys_i,
  input  wire logic                           rst_n_i,
  dpc_link_if.dev                             link,
  input  wire logic                           pll_enable_i,
  input  wire logic [dpc_pkg::CODE_W-1:0]     interp_code_i,
  input  wire logic [dpc_pkg::CODE_W-1:0]     prescale_code_i,
  input  wire logic                           zero_stuff_i,
  input  wire logic                           sleep_i,
  input  wire logic                           power_down_i,
  input  wire logic                           clk_on_sdo_i,
  input  wire logic                           pin_clock_out_i,
  output logic [dpc_pkg::RATIO_W-1:0]         vco_ratio_o,
  output logic                                lock_status_o,
  output logic                                dac_current_en_o,
  output logic                                digital_run_o,
  output logic [dpc_pkg::DATA_W-1:0]          cap_port1_o,
  output logic [dpc_pkg::DATA_W-1:0]          cap_port2_o,
  output logic                                cap_valid_o
);
  localparam logic [dpc_pkg::LOCK_W-1:0] LOCK_LAST = dpc_pkg::LOCK_W'(dpc_pkg::LOCK_CYCLES - 1);

  typedef enum logic [1:0] {DPC_OFF, DPC_ACQUIRE, DPC_LOCKED} dpc_lock_e;

  dpc_lock_e                     lock_state_reg;
  dpc_lock_e                     lock_state_next;
  logic [dpc_pkg::LOCK_W-1:0]    lock_cnt_reg;
  logic [dpc_pkg::LOCK_W-1:0]    lock_cnt_next;
  logic [2:0]                    ratio_log_reg;
  logic [dpc_pkg::CNT_W-1:0]     cnt_reg;
  logic [dpc_pkg::CNT_W-1:0]     cnt_next;
  logic                          dclk_reg;
  logic                          dclk_prev_reg;
  logic [dpc_pkg::RATIO_W-1:0]   ratio_reg;
  logic                          cap_valid_reg;
  logic [dpc_pkg::DATA_W-1:0]    cap1_reg;
  logic [dpc_pkg::DATA_W-1:0]    cap2_reg;

  wire                           running;
  wire [2:0]                     ratio_log;
  wire [2:0]                     div_log;
  // One bit wider than the counter so the longest period, 16, still fits
  wire [dpc_pkg::CNT_W:0]        raw_period;
  wire [dpc_pkg::CNT_W:0]        period;
  wire [dpc_pkg::CNT_W:0]        min_period_w;
  wire [dpc_pkg::CNT_W:0]        pll_period_w;
  wire [dpc_pkg::CNT_W-1:0]      half;
  wire                           dclk_rise;
  wire                           pll_live;
  wire                           lock_level;
  wire                           locked_state;
  wire                           route_src;

  // Power-down halts all digital work; sleep leaves it running
  assign running    = !power_down_i;
  assign pll_live   = pll_enable_i && running;

  // Oscillator multiple: interpolation x prescaler, again x2 with zero stuffing
  assign ratio_log  = 3'(interp_code_i) + 3'(prescale_code_i) + 3'(zero_stuff_i);

  // PLL off: input is the converter-rate clock, divided by interpolation (x2 when stuffing)
  assign div_log    = 3'(interp_code_i) + 3'(zero_stuff_i);
  assign min_period_w = {1'b0, dpc_pkg::MIN_PERIOD};
  assign pll_period_w = {1'b0, dpc_pkg::PLL_ON_PERIOD};
  assign raw_period = 5'h01 << div_log;
  // PLL on: input already runs at sample rate, so the data clock follows it
  assign period     = pll_enable_i ? pll_period_w
                    : ((raw_period < min_period_w) ? min_period_w : raw_period);
  assign half       = dpc_pkg::CNT_W'(period >> 1);
  // A shrunk period can leave the counter past its end; wrap at once
  assign cnt_next   = ({1'b0, cnt_reg} >= period - 5'h01) ? 4'h0 : cnt_reg + 4'h1;
  // Rise judged against last cycle's level, so the short first period after reset
  // or power-down still pairs one capture with one source hand-over
  assign dclk_rise  = running && dclk_reg && !dclk_prev_reg;

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      cnt_reg       <= 4'h0;
      dclk_reg      <= 1'b0;
      dclk_prev_reg <= 1'b0;
    end
    else if (running)
    begin
      cnt_reg       <= cnt_next;
      dclk_reg      <= (cnt_next < half);
      dclk_prev_reg <= dclk_reg;
    end
    else
    begin
      // Frozen low so the source sees no edges while powered down
      cnt_reg       <= 4'h0;
      dclk_reg      <= 1'b0;
      dclk_prev_reg <= 1'b0;
    end
  end

  // Loop model: any change of multiple or enable restarts acquisition
  always_comb
  begin
    lock_state_next = lock_state_reg;
    lock_cnt_next   = lock_cnt_reg;
    unique case (lock_state_reg)
      DPC_OFF:
      begin
        lock_cnt_next = '0;
        if (pll_live)
        begin
          lock_state_next = DPC_ACQUIRE;
        end
      end
      DPC_ACQUIRE:
      begin
        if (lock_cnt_reg == LOCK_LAST)
        begin
          lock_state_next = DPC_LOCKED;
        end
        else
        begin
          lock_cnt_next = lock_cnt_reg + 12'h001;
        end
      end
      DPC_LOCKED:
      begin
        lock_cnt_next = '0;
      end
    endcase
    if (!pll_live)
    begin
      lock_state_next = DPC_OFF;
      lock_cnt_next   = '0;
    end
    else if (ratio_log != ratio_log_reg && lock_state_reg != DPC_OFF)
    begin
      lock_state_next = DPC_ACQUIRE;
      lock_cnt_next   = '0;
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      lock_state_reg <= DPC_OFF;
      lock_cnt_reg   <= '0;
      ratio_log_reg  <= 3'h0;
      ratio_reg      <= 8'h01;
    end
    else
    begin
      lock_state_reg <= lock_state_next;
      lock_cnt_reg   <= lock_cnt_next;
      ratio_log_reg  <= ratio_log;
      ratio_reg      <= dpc_pkg::RATIO_W'(9'h001 << ratio_log);
    end
  end

  // Status bit mirrors the lock pin; no write path exists
  assign locked_state  = (lock_state_reg == DPC_LOCKED);
  // Gated by the live enable so a stopped loop never reads locked, even for a cycle
  assign lock_level    = locked_state && pll_live;
  assign lock_status_o = lock_level;
  assign vco_ratio_o   = ratio_reg;

  // Pin routing: clock when PLL off or clock-out chosen, otherwise lock indicator
  assign route_src = (!pll_enable_i || pin_clock_out_i) ? dclk_reg : lock_level;
  // Selection below covers PLL off, lock routing and clock routing alike
  assign link.shared_pin = clk_on_sdo_i ? 1'b0 : route_src;
  assign link.sdo_pin    = clk_on_sdo_i ? route_src : 1'b0;
  // Serial output driven only when it carries the clock or lock
  assign link.sdo_oe     = clk_on_sdo_i;
  // With PLL on and both select bits clear the lock reaches the shared pin
  // through route_src above; nothing else drives it.

  // Sleep only removes output current; logic keeps state, so return is immediate
  assign dac_current_en_o = !sleep_i && !power_down_i;
  assign digital_run_o    = running;

  // Both ports sampled together on the same data-clock edge
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      cap1_reg      <= '0;
      cap2_reg      <= '0;
      cap_valid_reg <= 1'b0;
    end
    else
    begin
      cap_valid_reg <= dclk_rise;
      if (dclk_rise)
      begin
        cap1_reg <= link.port1;
        cap2_reg <= link.port2;
      end
    end
  end

  assign cap_port1_o = cap1_reg;
  assign cap_port2_o = cap2_reg;
  assign cap_valid_o = cap_valid_reg;
endmodule

// file: logic/dpc_sample_source.sv
/*
  Source end: presents sample pairs on both ports after each data-clock rise
  seen on the chosen pin, checks the rate plan and holds off after power-down.
  Assumes the pins are synchronous to the shared system clock.
*/
`timescale 1ns/10ps
module dpc_sample_source (
  input  wire logic                           clk_sys_i,
  input  wire logic                           rst_n_i,
  dpc_link_if.src                             link,
  input  wire logic                           clk_on_sdo_i,
  input  wire logic [dpc_pkg::DATA_W-1:0]     word1_i,
  input  wire logic [dpc_pkg::DATA_W-1:0]     word2_i,
  input  wire logic                           word_valid_i,
  output logic                                word_ready_o,
  input  wire logic [dpc_pkg::RATE_W-1:0]     rate_msps_i,
  input  wire logic [dpc_pkg::CODE_W-1:0]     interp_code_i,
  input  wire logic [dpc_pkg::CODE_W-1:0]     prescale_code_i,
  input  wire logic                           zero_stuff_i,
  input  wire logic                           pll_enable_i,
  input  wire logic                           power_down_i,
  output logic                                rate_ok_o,
  output logic                                vco_ok_o,
  output logic [dpc_pkg::CODE_W-1:0]          suggested_div_o,
  output logic                                output_trusted_o
);
  logic                          pin_prev_reg;
  logic [dpc_pkg::DATA_W-1:0]    p1_reg;
  logic [dpc_pkg::DATA_W-1:0]    p2_reg;
  logic [dpc_pkg::FLUSH_W-1:0]   flush_reg;
  logic                          rate_ok_reg;
  logic                          vco_ok_reg;
  logic [dpc_pkg::CODE_W-1:0]    sugg_reg;

  wire                           clk_pin;
  wire                           rise;
  wire [8:0]                     rate9;
  wire [8:0]                     min_rate;
  wire [8:0]                     max_raw;
  wire [8:0]                     max_rate;
  wire [dpc_pkg::PROD_W-1:0]     vco_mhz;
  wire [dpc_pkg::CODE_W-1:0]     sugg;

  assign clk_pin      = clk_on_sdo_i ? link.sdo_pin : link.shared_pin;
  assign rise         = clk_pin && !pin_prev_reg;
  // New pair taken at the same edge the converter samples the old one
  assign word_ready_o = rise;

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      pin_prev_reg <= 1'b0;
      p1_reg       <= '0;
      p2_reg       <= '0;
    end
    else
    begin
      pin_prev_reg <= clk_pin;
      if (rise && word_valid_i)
      begin
        p1_reg <= word1_i;
        p2_reg <= word2_i;
      end
    end
  end

  assign link.port1 = p1_reg;
  assign link.port2 = p2_reg;

  // Table bounds: minimum halves per divider step; maximum from oscillator ceiling
  assign rate9    = 9'(rate_msps_i);
  assign min_rate = ((interp_code_i == 2'h0) ? dpc_pkg::MIN_BASE_X1 : dpc_pkg::MIN_BASE_XN)
                    >> prescale_code_i;
  assign max_raw  = (prescale_code_i == 2'h0 && interp_code_i >= 2'h2)
                    ? (dpc_pkg::MAX_BASE_DIV1 >> interp_code_i)
                    : (dpc_pkg::MAX_BASE >> (3'(interp_code_i) + 3'(prescale_code_i)));
  assign max_rate = (max_raw > dpc_pkg::RATE_CEIL) ? dpc_pkg::RATE_CEIL : max_raw;
  assign vco_mhz  = dpc_pkg::PROD_W'(rate9) << (3'(interp_code_i) + 3'(prescale_code_i) + 3'(zero_stuff_i));
  // Prescaler advice by input rate
  assign sugg     = (rate_msps_i >= dpc_pkg::RATE_DIV1) ? 2'h0
                  : (rate_msps_i >= dpc_pkg::RATE_DIV2) ? 2'h1
                  : (rate_msps_i >= dpc_pkg::RATE_DIV4) ? 2'h2 : 2'h3;

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      rate_ok_reg <= 1'b0;
      vco_ok_reg  <= 1'b0;
      sugg_reg    <= 2'h0;
    end
    else
    begin
      // Table limits only bind while the loop is in use; the RATE_CEIL cap always applies
      rate_ok_reg <= (rate9 <= dpc_pkg::RATE_CEIL)
                     && (!pll_enable_i || (rate9 >= min_rate && rate9 <= max_rate));
      vco_ok_reg  <= !pll_enable_i
                     || (vco_mhz >= dpc_pkg::VCO_LO_MHZ && vco_mhz <= dpc_pkg::VCO_HI_MHZ);
      sugg_reg    <= sugg;
    end
  end

  // Filters hold stale data after power-down; distrust output until flushed
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      flush_reg <= '0;
    end
    else if (power_down_i)
    begin
      flush_reg <= '0;
    end
    else if (flush_reg != dpc_pkg::FLUSH_W'(dpc_pkg::FLUSH_CYCLES))
    begin
      flush_reg <= flush_reg + 8'h01;
    end
  end

  assign output_trusted_o = (flush_reg == dpc_pkg::FLUSH_W'(dpc_pkg::FLUSH_CYCLES));
  assign rate_ok_o        = rate_ok_reg;
  assign vco_ok_o         = vco_ok_reg;
  assign suggested_div_o  = sugg_reg;
endmodule

// file: verif/dpc_link_assertions.sv
/*
  Assertions on the pins between the converter clock block and the source.
  Assumes one system clock; the bench instantiates it beside the link.
*/
`timescale 1ns/10ps
module dpc_link_assertions (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic shared_pin,
  input wire logic sdo_pin,
  input wire logic sdo_oe,
  input wire logic pll_enable_i,
  input wire logic clk_on_sdo_i,
  input wire logic pin_clock_out_i,
  input wire logic sleep_i,
  input wire logic power_down_i,
  input wire logic lock_status_o,
  input wire logic dac_current_en_o,
  input wire logic digital_run_o,
  input wire logic cap_valid_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  sdo_enable_a: assert property (sdo_oe == clk_on_sdo_i)
    else $error("sdo enable does not follow pin select");
  shared_quiet_a: assert property (clk_on_sdo_i |-> !shared_pin)
    else $error("shared pin active while sdo selected");
  lock_shared_a: assert property (pll_enable_i && !pin_clock_out_i && !clk_on_sdo_i |-> shared_pin == lock_status_o)
    else $error("lock not on shared pin");
  lock_sdo_a: assert property (pll_enable_i && !pin_clock_out_i && clk_on_sdo_i |-> sdo_pin == lock_status_o)
    else $error("lock not on sdo pin");
  sleep_gate_a: assert property (dac_current_en_o == !(sleep_i || power_down_i))
    else $error("converter current gating wrong");
  power_off_a: assert property ($past(power_down_i) && power_down_i |-> !digital_run_o && !lock_status_o && !shared_pin && !sdo_pin)
    else $error("activity during power-down");
  pll_off_lock_a: assert property (!$past(pll_enable_i) && !pll_enable_i |-> !lock_status_o)
    else $error("lock shown with loop off");
  // With the loop on the data clock is half the system rate
  fast_clock_a: assert property ($rose(shared_pin) && pll_enable_i && pin_clock_out_i |=> !shared_pin || !pll_enable_i)
    else $error("data clock too slow with loop on");
  // A routing switch mid-period is not a real rise, so routing must be steady
  cap_follow_a: assert property ($rose(shared_pin) && !clk_on_sdo_i && (!pll_enable_i || pin_clock_out_i) && !power_down_i
    && $stable(pll_enable_i) && $stable(pin_clock_out_i) && $stable(clk_on_sdo_i) |=> cap_valid_o)
    else $error("no capture after data clock rise");
  valid_pulse_a: assert property (cap_valid_o |=> !cap_valid_o)
    else $error("capture strobe longer than a cycle");

  cover property ($rose(lock_status_o));
  cover property (cap_valid_o);
  cover property ($rose(sdo_pin));
endmodule

// file: verif/dac_pll_clock_and_power_modes_bench.sv
/*
  Self-checking bench: converter clock block facing the sample source.
  Assumes both ends share clk_sys_i; a reference model checks each result.
*/
`timescale 1ns/10ps
module dac_pll_clock_and_power_modes_bench;
  logic        clk_sys_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        pll = 1'b0, zs = 1'b0, slp = 1'b0, pd = 1'b0, sdo_sel = 1'b1, pco = 1'b0, wv = 1'b0, track = 1'b0;
  logic [1:0]  interp = 2'h2, presc = 2'h0, sugg;
  logic [15:0] w1 = 16'h0000, w2 = 16'h0000, cap1, cap2;
  logic [7:0]  rate = 8'h00, vco_ratio;
  logic        lock, dac_en, run, cap_valid, ready, rate_ok, vco_ok, trusted;
  int          bad_count = 0, compares = 0, cycles = 0, n, r;
  logic [31:0] ports_m, exp_q[$];

  dpc_link_if lk();
  dpc_clock_ctrl u_dpc_clock_ctrl (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .link(lk), .pll_enable_i(pll),
    .interp_code_i(interp), .prescale_code_i(presc), .zero_stuff_i(zs), .sleep_i(slp), .power_down_i(pd),
    .clk_on_sdo_i(sdo_sel), .pin_clock_out_i(pco), .vco_ratio_o(vco_ratio), .lock_status_o(lock),
    .dac_current_en_o(dac_en), .digital_run_o(run), .cap_port1_o(cap1), .cap_port2_o(cap2), .cap_valid_o(cap_valid));
  dpc_sample_source u_dpc_sample_source (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .link(lk), .clk_on_sdo_i(sdo_sel),
    .word1_i(w1), .word2_i(w2), .word_valid_i(wv), .word_ready_o(ready), .rate_msps_i(rate), .interp_code_i(interp),
    .prescale_code_i(presc), .zero_stuff_i(zs), .pll_enable_i(pll), .power_down_i(pd), .rate_ok_o(rate_ok),
    .vco_ok_o(vco_ok), .suggested_div_o(sugg), .output_trusted_o(trusted));
  dpc_link_assertions u_dpc_link_assertions (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .shared_pin(lk.shared_pin),
    .sdo_pin(lk.sdo_pin), .sdo_oe(lk.sdo_oe), .pll_enable_i(pll), .clk_on_sdo_i(sdo_sel), .pin_clock_out_i(pco),
    .sleep_i(slp), .power_down_i(pd), .lock_status_o(lock), .dac_current_en_o(dac_en), .digital_run_o(run),
    .cap_valid_o(cap_valid));

  always #25 clk_sys_i = ~clk_sys_i;

  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys_i);
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e)
    begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic end_sim;
    if (bad_count == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic do_reset;
    rst_n_i <= 1'b0;
    cyc(6);
    rst_n_i <= 1'b1;
  endtask

  // Rate table bound: top=0 lowest rate, top=1 highest
  function automatic int lim(input int i, input int d, input int top);
    int hi;
    hi = (d == 0 && i >= 2) ? 400 >> i : 448 >> (i + d);
    return top ? (hi > 160 ? 160 : hi) : (i == 0 ? 32 : 24) >> d;
  endfunction

  // Pair model: a capture takes the pair loaded one data period earlier
  always @(posedge clk_sys_i)
  begin
    cycles++;
    if (track && cap_valid)
      chk({cap1, cap2}, exp_q.size() > 0 ? exp_q.pop_front() : 32'hdead_beef);
    if (track && ready)
    begin
      exp_q.push_back(ports_m);
      if (wv)
        ports_m = {w1, w2};
    end
    if (cycles == 20000)
    begin
      bad_count++;
      end_sim;
    end
  end

  initial
  begin
    void'($urandom(32'h758c));
    do_reset;
    ports_m = 32'h0000_0000;
    track = 1'b1;
    repeat (200)
    begin
      @(posedge clk_sys_i);
      w1 <= 16'($urandom);
      w2 <= 16'($urandom);
      wv <= 1'($urandom);
    end
    track = 1'b0;
    chk(32'(compares >= 45), 32'h1);
    for (int k = 0; k < 32; k++)
    begin
      {zs, presc, interp} <= 5'(k);
      cyc(2);
      chk(32'(vco_ratio), 32'h1 << ((k & 3) + ((k >> 2) & 3) + (k >> 4)));
    end
    {zs, presc, interp} <= 5'h00;
    for (int k = 0; k < 8; k++)
    begin
      {pll, sdo_sel, pco} <= 3'(k);
      cyc(2);
      n = 0;
      r = 0;
      repeat (16)
      begin
        @(posedge clk_sys_i);
        n += sdo_sel ? lk.sdo_pin : lk.shared_pin;
        r += sdo_sel ? lk.shared_pin : lk.sdo_pin;
      end
      chk(n, (k < 4 || k[0]) ? 8 : 0);
      chk(r, 0);
      chk(32'(lk.sdo_oe), 32'(k[1]));
    end
    {pll, sdo_sel, pco} <= 3'h0;
    cyc(3);
    // PLL off: data clock period is max(2, interpolation x stuffing factor)
    for (int k = 0; k < 8; k++)
    begin
      {zs, interp} <= 3'(k);
      cyc(4);
      n = 0;
      r = lk.shared_pin;
      repeat (64)
      begin
        @(posedge clk_sys_i);
        n += (lk.shared_pin && !r);
        r = lk.shared_pin;
      end
      chk(n, 64 / (((k & 3) + (k >> 2)) == 0 ? 2 : 1 << ((k & 3) + (k >> 2))));
    end
    {zs, interp} <= 3'h0;
    pll <= 1'b1;
    n = 0;
    while (lock !== 1'b1 && n < 400)
    begin
      cyc(1);
      n++;
    end
    chk(32'(n >= 199 && n <= 204), 32'h1);
    interp <= 2'h1;
    cyc(2);
    chk(32'(lock), 32'h0);
    for (int k = 0; k < 16; k++)
      for (int j = 0; j < 5; j++)
      begin
        interp <= 2'(k);
        presc <= 2'(k >> 2);
        r = j < 4 ? lim(k & 3, k >> 2, j >> 1) + (j == 0 ? -1 : j == 3 ? 1 : 0) : $urandom_range(130, 40);
        rate <= 8'(r);
        cyc(2);
        chk(32'(rate_ok), 32'(r >= lim(k & 3, k >> 2, 0) && r <= lim(k & 3, k >> 2, 1)));
        chk(32'(vco_ok), 32'((r << ((k & 3) + (k >> 2))) inside {[450:550]}));
        chk(32'(sugg), r >= 125 ? 0 : r >= 75 ? 1 : r >= 50 ? 2 : 3);
      end
    slp <= 1'b1;
    cyc(2);
    chk({dac_en, run}, 32'h1);
    slp <= 1'b0;
    cyc(1);
    chk(32'(dac_en), 32'h1);
    do_reset;
    pd <= 1'b1;
    cyc(5);
    chk({lock, run, lk.shared_pin, trusted}, 32'h0);
    pd <= 1'b0;
    cyc(60);
    chk(32'(trusted), 32'h0);
    cyc(10);
    chk(32'(trusted), 32'h1);
    end_sim;
  end
endmodule
